// ==== src/dncs_regs.svh ====
// Operation
// RULE1: Converter A uses two select pins, bit0 least and bit1 most significant.
// RULE2: Converter B has its own two-bit select with the same bit order.
// RULE3: Selected oscillator drives mixing only in a complex output mode.
// RULE4: Unselected oscillators keep advancing phase every sample for coherence.
// RULE5: Pin changes swap oscillators only while pin control mode is one.
// RULE6: Select pins are asynchronous and synchronised before use.
// RULE7: A new selection takes effect on one sample boundary, never partially.
`ifndef DNCS_REGS_SVH
`define DNCS_REGS_SVH

`define DNCS_NUM_OSC 4
`define DNCS_SEL_W 2
`define DNCS_PHASE_W 32
`define DNCS_SEL_RST 2'h0
`define DNCS_PHASE_RST 32'h0000_0000
`define DNCS_PIN_CTRL_ON 1'h1
`define DNCS_SYNC_STAGES 2

`endif

// ==== src/dncs_pkg.sv ====
package dncs_pkg;

  typedef struct packed {
    logic osc_sel_a_bit1;
    logic osc_sel_a_bit0;
    logic osc_sel_b_bit1;
    logic osc_sel_b_bit0;
  } dncs_pins_t;

  typedef struct packed {
    logic [31:0] phase_a;
    logic [31:0] phase_b;
    logic mix_en_a;
    logic mix_en_b;
  } dncs_mix_t;

  typedef enum logic [2:0] {
    DNCS_ST_FOLLOW = 3'h1,
    DNCS_ST_HOLD = 3'h2,
    DNCS_ST_BYPASS = 3'h4
  } dncs_state_t;

endpackage

// ==== src/dncs_osc_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dncs_regs.svh"

module dncs_osc_bank #(
  parameter int NUM_OSC = `DNCS_NUM_OSC,
  parameter int PHASE_W = `DNCS_PHASE_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [NUM_OSC*PHASE_W-1:0] freq_words,
  input wire logic [$clog2(NUM_OSC)-1:0] rd_sel,
  output logic [PHASE_W-1:0] rd_phase
);

  // Parameter check at elaboration
  if (NUM_OSC < 2 || PHASE_W < 1) begin : g_param_check
    $error("dncs_osc_bank: unsupported parameters");
  end

  logic [PHASE_W-1:0] acc_r [NUM_OSC];
  logic [PHASE_W-1:0] acc_nxt [NUM_OSC];
  logic [PHASE_W-1:0] rd_phase_nxt;

  // ****************************************
  // Phase accumulators
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_OSC; g++) begin : g_osc
      always_comb begin
        acc_nxt[g] = acc_r[g] + freq_words[g*PHASE_W +: PHASE_W]; // see RULE4
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          acc_r[g] <= '0;
        end else begin
          acc_r[g] <= acc_nxt[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Registered read port
  // ****************************************
  always_comb begin
    rd_phase_nxt = acc_r[rd_sel]; // see RULE7
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_phase <= '0;
    end else begin
      rd_phase <= rd_phase_nxt;
    end
  end

endmodule // dncs_osc_bank
`default_nettype wire

// ==== src/dncs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dncs_regs.svh"

module dncs_top #(
  parameter int PHASE_W = `DNCS_PHASE_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire dncs_pkg::dncs_pins_t sel_pins,
  input wire logic pin_control_mode,
  input wire logic interface_output_mode,
  input wire logic [`DNCS_NUM_OSC*PHASE_W-1:0] freq_words_a,
  input wire logic [`DNCS_NUM_OSC*PHASE_W-1:0] freq_words_b,
  output dncs_pkg::dncs_mix_t mix_out,
  output logic [`DNCS_SEL_W-1:0] active_sel_a,
  output logic [`DNCS_SEL_W-1:0] active_sel_b
);

  // Parameter check at elaboration
  if (PHASE_W != 32) begin : g_param_check
    $error("dncs_top: phase width must be 32");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync1_nxt;
  logic [3:0] sync2_nxt;

  always_comb begin
    sync1_nxt = sel_pins; // see RULE6
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // ****************************************
  // Mode sequencing
  // ****************************************
  dncs_pkg::dncs_state_t state_r;
  dncs_pkg::dncs_state_t state_nxt;

  always_comb begin
    if (!interface_output_mode) begin
      state_nxt = dncs_pkg::DNCS_ST_BYPASS; // see RULE3
    end else if (pin_control_mode == `DNCS_PIN_CTRL_ON) begin
      state_nxt = dncs_pkg::DNCS_ST_FOLLOW; // see RULE5
    end else begin
      state_nxt = dncs_pkg::DNCS_ST_HOLD;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= dncs_pkg::DNCS_ST_BYPASS;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Selection registers
  // ****************************************
  logic [`DNCS_SEL_W-1:0] pin_sel_a;
  logic [`DNCS_SEL_W-1:0] pin_sel_b;
  logic [`DNCS_SEL_W-1:0] sel_a_r;
  logic [`DNCS_SEL_W-1:0] sel_b_r;
  logic [`DNCS_SEL_W-1:0] sel_a_nxt;
  logic [`DNCS_SEL_W-1:0] sel_b_nxt;
  logic mix_en_r;
  logic mix_en_nxt;

  always_comb begin
    pin_sel_a = {sync2_r[3], sync2_r[2]}; // see RULE1
    pin_sel_b = {sync2_r[1], sync2_r[0]}; // see RULE2
    sel_a_nxt = sel_a_r;
    sel_b_nxt = sel_b_r;
    mix_en_nxt = 1'h0;
    case (state_r)
      dncs_pkg::DNCS_ST_FOLLOW: begin
        sel_a_nxt = pin_sel_a; // see RULE5
        sel_b_nxt = pin_sel_b;
        mix_en_nxt = 1'h1;
      end
      dncs_pkg::DNCS_ST_HOLD: begin
        mix_en_nxt = 1'h1;
      end
      dncs_pkg::DNCS_ST_BYPASS: begin
        mix_en_nxt = 1'h0; // see RULE3
      end
      default: begin
        sel_a_nxt = `DNCS_SEL_RST;
        sel_b_nxt = `DNCS_SEL_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_a_r <= `DNCS_SEL_RST;
      sel_b_r <= `DNCS_SEL_RST;
      mix_en_r <= 1'h0;
    end else begin
      sel_a_r <= sel_a_nxt; // see RULE7
      sel_b_r <= sel_b_nxt;
      mix_en_r <= mix_en_nxt;
    end
  end

  // ****************************************
  // Oscillator banks
  // ****************************************
  logic [PHASE_W-1:0] phase_a;
  logic [PHASE_W-1:0] phase_b;

  dncs_osc_bank #(.NUM_OSC(`DNCS_NUM_OSC), .PHASE_W(PHASE_W)) u_bank_a (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .freq_words(freq_words_a),
    .rd_sel(sel_a_r),
    .rd_phase(phase_a)
  );

  dncs_osc_bank #(.NUM_OSC(`DNCS_NUM_OSC), .PHASE_W(PHASE_W)) u_bank_b (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .freq_words(freq_words_b),
    .rd_sel(sel_b_r),
    .rd_phase(phase_b)
  );

  // ****************************************
  // Output registers
  // ****************************************
  dncs_pkg::dncs_mix_t mix_nxt;
  logic [`DNCS_SEL_W-1:0] act_a_nxt;
  logic [`DNCS_SEL_W-1:0] act_b_nxt;
  logic mix_en_d_r;
  logic mix_en_d_nxt;

  always_comb begin
    mix_en_d_nxt = mix_en_r;
    act_a_nxt = sel_a_r;
    act_b_nxt = sel_b_r;
    mix_nxt.phase_a = mix_en_d_r ? phase_a : `DNCS_PHASE_RST; // see RULE3
    mix_nxt.phase_b = mix_en_d_r ? phase_b : `DNCS_PHASE_RST;
    mix_nxt.mix_en_a = mix_en_d_r;
    mix_nxt.mix_en_b = mix_en_d_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mix_en_d_r <= 1'h0;
      mix_out <= '0;
      active_sel_a <= `DNCS_SEL_RST;
      active_sel_b <= `DNCS_SEL_RST;
    end else begin
      mix_en_d_r <= mix_en_d_nxt;
      mix_out <= mix_nxt;
      active_sel_a <= act_a_nxt;
      active_sel_b <= act_b_nxt;
    end
  end

endmodule // dncs_top
`default_nettype wire

// ==== tb/dncs_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dncs_regs.svh"
// ********
// Checker
// ********
module dncs_top_check #(
  parameter int PHASE_W = 32
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire dncs_pkg::dncs_pins_t sel_pins,
  input wire logic pin_control_mode,
  input wire logic interface_output_mode,
  input wire logic [`DNCS_NUM_OSC*PHASE_W-1:0] freq_words_a,
  input wire logic [`DNCS_NUM_OSC*PHASE_W-1:0] freq_words_b,
  input wire dncs_pkg::dncs_mix_t mix_out,
  input wire logic [1:0] active_sel_a,
  input wire logic [1:0] active_sel_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic [1:0] pa = {sel_pins.osc_sel_a_bit1, sel_pins.osc_sel_a_bit0};
  wire logic [1:0] pb = {sel_pins.osc_sel_b_bit1, sel_pins.osc_sel_b_bit0};
  wire logic on = pin_control_mode && interface_output_mode;
  sequence s_on_a;
    (on && $stable(pa))[*8];
  endsequence
  sequence s_on_b;
    (on && $stable(pb))[*8];
  endsequence
  a_sel_a_follow: assert property (s_on_a |-> active_sel_a == pa)
    else $error("sel a wrong");
  a_sel_b_follow: assert property (s_on_b |-> active_sel_b == pb)
    else $error("sel b wrong");
  a_mix_gate: assert property ((!interface_output_mode)[*6] |->
    !mix_out.mix_en_a && !mix_out.mix_en_b && mix_out.phase_a == 0 && mix_out.phase_b == 0)
    else $error("mix on");
  a_pins_ignored: assert property ((!pin_control_mode)[*6] |->
    $stable(active_sel_a) && $stable(active_sel_b)) else $error("sel moved");
  a_sync_lag: assert property ($stable(pa)[*3] ##1 $changed(pa) |=>
    $stable(active_sel_a)[*2]) else $error("no sync");
  a_phase_step_a: assert property ((mix_out.mix_en_a && $stable(active_sel_a))[*4] |->
    mix_out.phase_a - $past(mix_out.phase_a) == freq_words_a[active_sel_a*PHASE_W +: PHASE_W])
    else $error("step a");
  a_phase_step_b: assert property ((mix_out.mix_en_b && $stable(active_sel_b))[*4] |->
    mix_out.phase_b - $past(mix_out.phase_b) == freq_words_b[active_sel_b*PHASE_W +: PHASE_W])
    else $error("step b");
endmodule // dncs_top_check
bind dncs_top dncs_top_check #(.PHASE_W(PHASE_W)) dncs_top_check_i (.*);
`default_nettype wire

// ==== tb/dncs_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Controller
// ********
module dncs_ctrl_model (
  input wire logic clk_sys,
  input wire logic [1:0] want_a,
  input wire logic [1:0] want_b,
  output var dncs_pkg::dncs_pins_t sel_pins
);
  initial sel_pins = '0;
  // Both bits of a select move together
  always @(negedge clk_sys) sel_pins <= {want_a, want_b};
endmodule // dncs_ctrl_model
`default_nettype wire

// ==== tb/dncs_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module dncs_top_bench;
  logic clk_sys = 0, arst_n = 0, pin_control_mode = 0, interface_output_mode = 0;
  logic [1:0] wa = 0, wb = 0, active_sel_a, active_sel_b;
  logic [127:0] freq_words_a = {32'h4, 32'h3, 32'h2, 32'h1};
  logic [127:0] freq_words_b = {32'h8, 32'h7, 32'h6, 32'h5};
  dncs_pkg::dncs_pins_t sel_pins;
  dncs_pkg::dncs_mix_t mix_out;
  int fail_count = 0, samples_checked = 0, cyc = 0, lat;
  dncs_ctrl_model dncs_ctrl_model_i (.clk_sys, .want_a(wa), .want_b(wb), .sel_pins);
  dncs_top dncs_top_i (.clk_sys, .arst_n, .sel_pins, .pin_control_mode,
    .interface_output_mode, .freq_words_a, .freq_words_b, .mix_out, .active_sel_a,
    .active_sel_b);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (arst_n) cyc <= cyc + 1;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_follow;
    pin_control_mode = 1;
    interface_output_mode = 1;
    wt(10);
    lat = cyc - mix_out.phase_a;
    for (int k = 0; k < 4; k++) begin
      wa <= 2'(k);
      wb <= 2'(3 - k);
      wt(8);
      chk(32'(active_sel_a), 32'(k));
      chk(32'(active_sel_b), 32'(3 - k));
      chk(mix_out.phase_a, 32'((cyc - lat) * (k + 1)));
      chk(mix_out.phase_b, 32'((cyc - lat) * (8 - k)));
    end
  endtask
  task automatic t_hold;
    pin_control_mode = 0;
    wa <= 2'h1;
    wb <= 2'h2;
    wt(8);
    chk(32'(active_sel_a), 32'h3);
    pin_control_mode = 1;
    wt(8);
    chk(32'(active_sel_b), 32'h2);
  endtask
  task automatic t_off;
    interface_output_mode = 0;
    wt(8);
    chk(mix_out.phase_b, 32'h0);
    chk(32'({mix_out.mix_en_a, mix_out.mix_en_b}), 32'h0);
    interface_output_mode = 1;
    wt(8);
    chk(32'(mix_out.mix_en_a), 32'h1);
  endtask
  task report_and_stop;
    $display("fails %0d checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    wt(12);
    chk(mix_out.phase_a, 32'h0);
    arst_n = 1;
    t_follow;
    t_hold;
    t_off;
    report_and_stop;
  end
  initial begin
    #20000;
    fail_count++;
    report_and_stop;
  end
endmodule // dncs_top_bench
`default_nettype wire
